// ### src/dsp_pkg.sv
// ---------------------------------------------------------------------------
// shared constants and carriers of the burst access port
// ---------------------------------------------------------------------------
package dsp_pkg;

  // largest size of each field over all organisations; smaller ones use its low bits
  localparam int DSP_DQ_MAX = 36;
  localparam int DSP_SEL_MAX = 4;
  localparam int DSP_NIB_SEL = 2;
  localparam int DSP_ADDR_MAX = 22;

  // data widths of the four organisations
  localparam int DSP_ORG_X8 = 8;
  localparam int DSP_ORG_X9 = 9;
  localparam int DSP_ORG_X18 = 18;
  localparam int DSP_ORG_X36 = 36;

  // lane widths for nibble and byte write selects
  localparam int DSP_NIBBLE_W = 4;
  localparam int DSP_BYTE_W = 9;

  // external address inputs per organisation
  localparam int DSP_AW_X36 = 21;
  localparam int DSP_AW_OTHER = 22;

  // words per burst and number of array halves
  localparam int DSP_BURST_LEN = 2;

  // output clock edges counted after a load before the first read word
  localparam logic [2:0] DSP_FIRST_EDGE_PLL = 3'h3;
  localparam logic [2:0] DSP_FIRST_EDGE_NOPLL = 3'h2;

  // read bursts that may be in flight at once
  localparam int DSP_RD_SLOTS = 2;

  // write word buffer depth
  localparam int DSP_FIFO_DEPTH = 16;

  // level of the direction input that asks for a read
  localparam logic DSP_DIR_READ = 1'b1;

  // every pin that crosses into the core clock, sampled as one group
  typedef struct packed {
    logic kClk;
    logic kClkN;
    logic cClk;
    logic cClkN;
    logic loadN;
    logic readNotWrite;
    logic pllDisableN;
    logic singleClock;
    logic [DSP_ADDR_MAX-1:0] addr;
    logic [DSP_DQ_MAX-1:0] dq;
    logic [DSP_SEL_MAX-1:0] selN;
  } dsp_pins_t;

  // one captured write word on its way to the array
  typedef struct packed {
    logic half;
    logic [DSP_ADDR_MAX-1:0] idx;
    logic [DSP_DQ_MAX-1:0] data;
    logic [DSP_DQ_MAX-1:0] bitEn;
  } dsp_wr_word_t;

  typedef enum {WR_IDLE, WR_WORD0, WR_WORD1} dsp_wr_state_t;

endpackage : dsp_pkg

// ### src/dsp_fifo.sv
`timescale 1ns/1ps
module dsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = store[rdPtr_q];

  always_ff @(posedge clk) begin
    if (push) begin
      store[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dsp_fifo

// ### src/dsp_half_ram.sv
`timescale 1ns/1ps
module dsp_half_ram #(
  parameter int WIDTH = 36,
  parameter int AW = 20
) (
  // clock
  input wire logic clk,
  // single shared port
  input wire logic en,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wData,
  input wire logic [WIDTH-1:0] bitEn,
  output logic [WIDTH-1:0] rData
);
  logic [WIDTH-1:0] mem [2**AW];

  // unselected bits keep their old contents
  always_ff @(posedge clk) begin
    if (en && we) begin
      mem[addr] <= (mem[addr] & ~bitEn) | (wData & bitEn);
    end
  end

  always_ff @(posedge clk) begin
    if (en && !we) begin
      rData <= mem[addr];
    end
  end
endmodule : dsp_half_ram

// ### src/dsp_access_port.sv
`timescale 1ns/1ps
// Overview of operation
// - each access moves exactly two words
// - direction high reads, low writes, under load
// - accesses start on true input clock rise
// - address, control and first write word captured on true input clock rise
// - second write word on complementary clock rise
// - read words leave on output clock rises, or input clock rises in single-clock mode
// - byte selects qualify lanes of same word
// - select n gates nine-bit lane n
// - unselected bytes stay unchanged in array
// - x8: two nibble selects per word
// - deselected nibble dropped, array nibble kept
// - x8/x9: burst always starts at word zero
// - x18/x36: lowest address bit seeds counter
// - shared address, array split in halves
// - address ignored without a load
// - data pins released when no read
// - free-running echo clocks follow output clock, or input clock in single-clock mode
// - pll off: one-cycle read latency
module dsp_access_port
  import dsp_pkg::*;
#(
  parameter int DQ_W = DSP_ORG_X36
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // input and output clock pairs from the controller
  input wire logic kClk,
  input wire logic kClkN,
  input wire logic cClk,
  input wire logic cClkN,
  // mode straps
  input wire logic singleClockMode,
  input wire logic pllDisableN,
  // command
  input wire logic loadStrobeN,
  input wire logic readNotWrite,
  input wire logic [dsp_pkg::DSP_ADDR_MAX-1:0] addr,
  // write masks
  input wire logic [dsp_pkg::DSP_SEL_MAX-1:0] byteWriteSelN,
  input wire logic [dsp_pkg::DSP_NIB_SEL-1:0] nibbleWriteSelN,
  // shared data pins
  input wire logic [dsp_pkg::DSP_DQ_MAX-1:0] dqIn,
  output logic [dsp_pkg::DSP_DQ_MAX-1:0] dqOut,
  output logic dqOe,
  // echo clocks
  output logic echoTiming,
  output logic echoTimingN,
  // write buffer has room
  output logic wrBufReady
);
  import dsp_pkg::*;

  // ---------------------------------------------------------------------
  // organisation
  // ---------------------------------------------------------------------
  localparam bit NIBBLE = (DQ_W == DSP_ORG_X8);
  localparam bit USE_LSB = (DQ_W >= DSP_ORG_X18);
  localparam int LANE_W = NIBBLE ? DSP_NIBBLE_W : DSP_BYTE_W;
  localparam int EXT_AW = (DQ_W == DSP_ORG_X36) ? DSP_AW_X36 : DSP_AW_OTHER;
  localparam int HALF_AW = USE_LSB ? EXT_AW - 1 : EXT_AW;
  localparam logic [DSP_ADDR_MAX-1:0] ADDR_MASK =
    {DSP_ADDR_MAX{1'b1}} >> (DSP_ADDR_MAX - EXT_AW);
  localparam logic [DSP_DQ_MAX-1:0] DQ_MASK =
    {DSP_DQ_MAX{1'b1}} >> (DSP_DQ_MAX - DQ_W);

  if (DQ_W != DSP_ORG_X8 && DQ_W != DSP_ORG_X9 &&
      DQ_W != DSP_ORG_X18 && DQ_W != DSP_ORG_X36) begin : g_chk
    $error("data width must be 8, 9, 18 or 36");
  end

  // ---------------------------------------------------------------------
  // pin synchroniser and edge finder
  // ---------------------------------------------------------------------
  dsp_pins_t pinRaw, pinMeta_q, pinSync_q, pinPrev_q;

  // carrier field order; x8 reads the unused upper selects as deselected
  assign pinRaw = {kClk, kClkN, cClk, cClkN, loadStrobeN, readNotWrite,
                   pllDisableN, singleClockMode, addr, dqIn,
                   NIBBLE ? {2'h3, nibbleWriteSelN} : byteWriteSelN};

  // whole group moves together so data and clocks keep their alignment
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
      pinPrev_q <= '0;
    end else begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end

  logic kRise, kNRise, outTrueRise, outCompRise, outEdge;

  assign kRise = pinSync_q.kClk & ~pinPrev_q.kClk;
  assign kNRise = pinSync_q.kClkN & ~pinPrev_q.kClkN;
  // single-clock mode launches read data from the input pair instead
  assign outTrueRise = pinSync_q.singleClock ? kRise :
                       (pinSync_q.cClk & ~pinPrev_q.cClk);
  assign outCompRise = pinSync_q.singleClock ? kNRise :
                       (pinSync_q.cClkN & ~pinPrev_q.cClkN);
  assign outEdge = outTrueRise | outCompRise;

  // ---------------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------------
  logic loadReq, rdIssue, wrLoad, loadLsb;
  logic [DSP_ADDR_MAX-1:0] addrMasked, loadIdx;

  // only a true-clock rise with load low starts anything
  assign loadReq = kRise & ~pinSync_q.loadN;
  assign rdIssue = loadReq & (pinSync_q.readNotWrite == DSP_DIR_READ);
  assign wrLoad = loadReq & (pinSync_q.readNotWrite != DSP_DIR_READ);
  assign addrMasked = pinSync_q.addr & ADDR_MASK;
  // burst counter seed: low address bit, or forced zero
  assign loadIdx = USE_LSB ? (addrMasked >> 1) : addrMasked;
  assign loadLsb = USE_LSB ? pinSync_q.addr[0] : 1'b0;

  // ---------------------------------------------------------------------
  // per-bit write enables from the lane selects
  // ---------------------------------------------------------------------
  logic [DSP_DQ_MAX-1:0] laneBitEn;

  for (genvar b = 0; b < DSP_DQ_MAX; b++) begin : g_bit
    if (b < DQ_W) begin : g_on
      // lane n covers bits n*LANE_W upward
      assign laneBitEn[b] = ~pinSync_q.selN[b / LANE_W];
    end else begin : g_off
      assign laneBitEn[b] = 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // write burst capture
  // ---------------------------------------------------------------------
  dsp_wr_state_t wrState_q;
  logic [DSP_ADDR_MAX-1:0] wrIdx_q, pendIdx_q;
  logic wrLsb_q, pendValid_q, pendLsb_q;

  // address is latched under a load or when a burst is abandoned; otherwise pins are ignored
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrState_q <= WR_IDLE;
      wrIdx_q <= '0;
      wrLsb_q <= 1'b0;
      pendValid_q <= 1'b0;
      pendIdx_q <= '0;
      pendLsb_q <= 1'b0;
    end else if (kRise) begin
      case (wrState_q)
        WR_IDLE: begin
          if (wrLoad) begin
            wrState_q <= WR_WORD0;
            wrIdx_q <= loadIdx;
            wrLsb_q <= loadLsb;
          end
        end
        WR_WORD0: begin
          // first data word taken on this edge; a new write may queue
          wrState_q <= WR_WORD1;
          if (wrLoad) begin
            pendValid_q <= 1'b1;
            pendIdx_q <= loadIdx;
            pendLsb_q <= loadLsb;
          end
        end
        default: begin
          // missing complementary edge: burst is abandoned
          wrState_q <= wrLoad ? WR_WORD0 : WR_IDLE;
          wrIdx_q <= loadIdx;
          wrLsb_q <= loadLsb;
        end
      endcase
    end else if (kNRise && wrState_q == WR_WORD1) begin
      // second word closes the burst; pick up a queued write if any
      wrState_q <= pendValid_q ? WR_WORD0 : WR_IDLE;
      wrIdx_q <= pendIdx_q;
      wrLsb_q <= pendLsb_q;
      pendValid_q <= 1'b0;
    end
  end

  logic fillValid, fillReady, drainValid, drainReady;
  dsp_wr_word_t fillWord, drainWord;

  assign fillValid = (kRise && wrState_q == WR_WORD0) ||
                     (kNRise && wrState_q == WR_WORD1);

  always_comb begin
    // word 0 goes to the half named by the counter, word 1 to the other
    fillWord.half = (wrState_q == WR_WORD0) ? wrLsb_q : ~wrLsb_q;
    fillWord.idx = wrIdx_q;
    fillWord.data = pinSync_q.dq & DQ_MASK;
    fillWord.bitEn = laneBitEn;
  end

  // reads own the array port; buffered writes wait a cycle
  assign drainReady = ~rdIssue;
  assign wrBufReady = fillReady;

  dsp_fifo #(
    .WIDTH($bits(dsp_wr_word_t)),
    .DEPTH(DSP_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(core_clk),
    .rst(sys_rst),
    .inValid(fillValid),
    .inReady(fillReady),
    .inData(fillWord),
    .outValid(drainValid),
    .outReady(drainReady),
    .outData(drainWord)
  );

  // ---------------------------------------------------------------------
  // array halves
  // ---------------------------------------------------------------------
  logic [DSP_DQ_MAX-1:0] ramRd [DSP_BURST_LEN];
  logic drainFire;

  assign drainFire = drainValid & drainReady;

  for (genvar h = 0; h < DSP_BURST_LEN; h++) begin : g_half
    logic hWr;
    logic [HALF_AW-1:0] hAddr;

    assign hWr = drainFire & (drainWord.half == 1'(h));
    // one address serves reads and writes alike
    assign hAddr = rdIssue ? loadIdx[HALF_AW-1:0] :
                   drainWord.idx[HALF_AW-1:0];

    dsp_half_ram #(
      .WIDTH(DSP_DQ_MAX),
      .AW(HALF_AW)
    ) u_ram (
      .clk(core_clk),
      .en(rdIssue | hWr),
      .we(hWr),
      .addr(hAddr),
      .wData(drainWord.data),
      .bitEn(drainWord.bitEn),
      .rData(ramRd[h])
    );
  end

  // ---------------------------------------------------------------------
  // read burst slots
  // ---------------------------------------------------------------------
  logic rdNext_q, rdFill_q, rdFillSlot_q, rdFillLsb_q;
  logic [DSP_RD_SLOTS-1:0] slotValid_q;
  logic [2:0] slotCnt_q [DSP_RD_SLOTS];
  logic [DSP_DQ_MAX-1:0] slotW0_q [DSP_RD_SLOTS], slotW1_q [DSP_RD_SLOTS];
  logic [2:0] firstEdge, secondEdge;

  // pll off falls back to the shorter, single-rate style latency
  assign firstEdge = pinSync_q.pllDisableN ? DSP_FIRST_EDGE_PLL :
                     DSP_FIRST_EDGE_NOPLL;
  assign secondEdge = firstEdge + 3'h1;

  // array data lands one cycle after the load edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdNext_q <= 1'b0;
      rdFill_q <= 1'b0;
      rdFillSlot_q <= 1'b0;
      rdFillLsb_q <= 1'b0;
    end else begin
      rdFill_q <= rdIssue;
      if (rdIssue) begin
        rdNext_q <= ~rdNext_q;
        rdFillSlot_q <= rdNext_q;
        rdFillLsb_q <= loadLsb;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slotValid_q <= '0;
      slotCnt_q <= '{default: '0};
      slotW0_q <= '{default: '0};
      slotW1_q <= '{default: '0};
    end else begin
      for (int s = 0; s < DSP_RD_SLOTS; s++) begin
        if (outEdge && slotValid_q[s]) begin
          slotCnt_q[s] <= slotCnt_q[s] + 3'h1;
          if (slotCnt_q[s] + 3'h1 == secondEdge) begin
            slotValid_q[s] <= 1'b0;
          end
        end
        // the load edge itself is not counted, even in single-clock mode
        if (rdIssue && rdNext_q == 1'(s)) begin
          slotValid_q[s] <= 1'b1;
          slotCnt_q[s] <= '0;
        end
        if (rdFill_q && rdFillSlot_q == 1'(s)) begin
          slotW0_q[s] <= rdFillLsb_q ? ramRd[1] : ramRd[0];
          slotW1_q[s] <= rdFillLsb_q ? ramRd[0] : ramRd[1];
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // read data launch and pin drive
  // ---------------------------------------------------------------------
  logic launchHit;
  logic [DSP_DQ_MAX-1:0] launchData;

  always_comb begin
    launchHit = 1'b0;
    launchData = '0;
    for (int s = 0; s < DSP_RD_SLOTS; s++) begin
      if (outEdge && slotValid_q[s]) begin
        if (slotCnt_q[s] + 3'h1 == firstEdge) begin
          launchHit = 1'b1;
          launchData = slotW0_q[s];
        end else if (slotCnt_q[s] + 3'h1 == secondEdge) begin
          launchHit = 1'b1;
          launchData = slotW1_q[s];
        end
      end
    end
  end

  logic [DSP_DQ_MAX-1:0] dqOut_q;
  logic dqOe_q;

  // each word holds the pins until the next output edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dqOut_q <= '0;
      dqOe_q <= 1'b0;
    end else if (outEdge) begin
      if (launchHit) begin
        dqOut_q <= launchData;
      end
      dqOe_q <= launchHit;
    end
  end

  assign dqOut = dqOut_q;
  assign dqOe = dqOe_q;

  // ---------------------------------------------------------------------
  // echo clocks
  // ---------------------------------------------------------------------
  logic echoTiming_q, echoTimingN_q;

  // echoes share the same sampling delay as the launched data
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      echoTiming_q <= 1'b0;
      echoTimingN_q <= 1'b0;
    end else begin
      echoTiming_q <= pinSync_q.singleClock ? pinSync_q.kClk :
                      pinSync_q.cClk;
      echoTimingN_q <= pinSync_q.singleClock ? pinSync_q.kClkN :
                       pinSync_q.cClkN;
    end
  end

  assign echoTiming = echoTiming_q;
  assign echoTimingN = echoTimingN_q;

endmodule : dsp_access_port

// ### sim/dsp_access_port_chk.sv
`timescale 1ns/1ps
module dsp_access_port_chk
  import dsp_pkg::*;
(
  // clocks and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic kClk,
  input wire logic kClkN,
  input wire logic cClk,
  // straps and command
  input wire logic singleClockMode,
  input wire logic pllDisableN,
  input wire logic loadStrobeN,
  input wire logic readNotWrite,
  // read side
  input wire logic [dsp_pkg::DSP_DQ_MAX-1:0] dqOut,
  input wire logic dqOe,
  input wire logic echoTiming,
  input wire logic echoTimingN
);
  // --------------------------------
  // age of the last read load
  // --------------------------------
  logic kPrev_q;
  logic [5:0] rdAge_q;
  logic [2:0] warm_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) kPrev_q <= 1'b1;
    else kPrev_q <= kClk;
  end

  // saturates so a stale read can never look recent
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) rdAge_q <= 6'h3f;
    else if (kClk && !kPrev_q && !loadStrobeN && readNotWrite)
      rdAge_q <= 6'h00;
    else if (rdAge_q != 6'h3f) rdAge_q <= rdAge_q + 6'h01;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) warm_q <= 3'h0;
    else if (warm_q != 3'h7) warm_q <= warm_q + 3'h1;
  end

  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_two_words;
    dqOe [*8];
  endsequence
  sequence s_word_hold;
    $stable(dqOut) [*3];
  endsequence

  chk_lat_pll_on: assert property (
    $rose(dqOe) && pllDisableN |-> rdAge_q inside {[12:17]})
    else $error("read latency wrong with pll on");
  chk_lat_pll_off: assert property (
    $rose(dqOe) && !pllDisableN |-> rdAge_q inside {[8:13]})
    else $error("read latency wrong with pll off");
  chk_two_words: assert property (
    $rose(dqOe) |-> s_two_words)
    else $error("read burst not two words long");
  chk_word_hold: assert property (
    $rose(dqOe) |=> s_word_hold ##2 s_word_hold)
    else $error("read word changed off an output edge");
  chk_idle_off: assert property (
    rdAge_q > 6'd24 |-> !dqOe)
    else $error("data driven with no read active");
  chk_hold_idle: assert property (
    !dqOe && !$past(dqOe) |-> $stable(dqOut))
    else $error("data changed while released");
  chk_echo_true: assert property (
    warm_q == 3'h7 && !singleClockMode
    && $past(singleClockMode, 4) == singleClockMode
    |-> echoTiming == $past(cClk, 3))
    else $error("echo does not follow output clock");
  chk_echo_comp: assert property (
    warm_q == 3'h7 && singleClockMode
    && $past(singleClockMode, 4) == singleClockMode
    |-> echoTimingN == $past(kClkN, 3))
    else $error("echo does not follow input clock");
endmodule : dsp_access_port_chk

bind dsp_access_port dsp_access_port_chk u_chk (.core_clk, .sys_rst,
  .kClk, .kClkN, .cClk, .singleClockMode, .pllDisableN, .loadStrobeN,
  .readNotWrite, .dqOut, .dqOe, .echoTiming, .echoTimingN);

// ### sim/dsp_ctrl_model.sv
`timescale 1ns/1ps
module dsp_ctrl_model
  import dsp_pkg::*;
(
  // core clock and mode
  input wire logic core_clk,
  input wire logic singleClockMode,
  // clock pairs
  output logic kClk,
  output logic kClkN,
  output logic cClk,
  output logic cClkN,
  // command and write side
  output logic loadStrobeN,
  output logic readNotWrite,
  output logic [dsp_pkg::DSP_ADDR_MAX-1:0] addr,
  output logic [dsp_pkg::DSP_SEL_MAX-1:0] byteWriteSelN,
  output logic [dsp_pkg::DSP_DQ_MAX-1:0] dqDrive,
  // read side
  input wire logic [dsp_pkg::DSP_DQ_MAX-1:0] dqOut,
  input wire logic dqOe
);
  // --------------------------------
  // clocks: output pair stands still in single mode
  // --------------------------------
  initial begin
    kClk = 1'b0;
    #7;
    forever #160 kClk = ~kClk;
  end
  assign kClkN = ~kClk;
  assign cClk = singleClockMode ? 1'b0 : kClk;
  assign cClkN = singleClockMode ? 1'b0 : kClkN;

  initial begin
    loadStrobeN = 1'b1;
    readNotWrite = 1'b0;
    addr = 22'h0;
    byteWriteSelN = 4'hf;
    dqDrive = 36'h0;
  end

  // --------------------------------
  // transfers; pins change mid-phase for margin
  // --------------------------------
  task automatic wr(input logic [21:0] a, input logic [35:0] d0, d1,
                    input logic [3:0] s0, s1, input logic ld);
    @(posedge kClk);
    #80;
    loadStrobeN = ld;
    readNotWrite = ~DSP_DIR_READ;
    addr = a;
    @(posedge kClk);
    #80;
    loadStrobeN = 1'b1;
    readNotWrite = DSP_DIR_READ;
    addr = ~a;
    dqDrive = d0;
    byteWriteSelN = s0;
    #320;
    dqDrive = d1;
    byteWriteSelN = s1;
    #160;
    // hold over: show the inverse, not a stale word
    dqDrive = ~d1;
    byteWriteSelN = 4'hf;
  endtask : wr

  task automatic rd(input logic [21:0] a, output logic [35:0] w0, w1);
    int n;
    @(posedge kClk);
    #80;
    loadStrobeN = 1'b0;
    readNotWrite = DSP_DIR_READ;
    addr = a;
    @(posedge kClk);
    #80;
    loadStrobeN = 1'b1;
    readNotWrite = ~DSP_DIR_READ;
    addr = ~a;
    w0 = 36'hxxxxxxxxx;
    w1 = 36'hxxxxxxxxx;
    n = 0;
    while (dqOe !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n < 40) begin
      #80;
      w0 = dqOut;
      #160;
      w1 = dqOut;
    end
  endtask : rd
endmodule : dsp_ctrl_model

// ### sim/dsp_access_port_tb_top.sv
`timescale 1ns/1ps
module dsp_access_port_tb_top;
  logic core_clk, sys_rst, singleClockMode, pllDisableN;
  logic kClk, kClkN, cClk, cClkN, loadStrobeN, readNotWrite;
  logic dqOe, echoTiming, echoTimingN, wrBufReady;
  logic [21:0] addr;
  logic [3:0] byteWriteSelN;
  logic [35:0] dqDrive, dqIn, dqOut, m0, m1;
  int mismatches, samples_checked;

  // shared pins: device wins while it drives
  assign dqIn = dqOe ? dqOut : dqDrive;

  dsp_access_port dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .kClk(kClk), .kClkN(kClkN), .cClk(cClk), .cClkN(cClkN),
    .singleClockMode(singleClockMode), .pllDisableN(pllDisableN),
    .loadStrobeN(loadStrobeN), .readNotWrite(readNotWrite),
    .addr(addr), .byteWriteSelN(byteWriteSelN),
    .nibbleWriteSelN(2'h3), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
    .echoTiming(echoTiming), .echoTimingN(echoTimingN),
    .wrBufReady(wrBufReady));

  dsp_ctrl_model model (.core_clk(core_clk),
    .singleClockMode(singleClockMode), .kClk(kClk), .kClkN(kClkN),
    .cClk(cClk), .cClkN(cClkN), .loadStrobeN(loadStrobeN),
    .readNotWrite(readNotWrite), .addr(addr),
    .byteWriteSelN(byteWriteSelN), .dqDrive(dqDrive), .dqOut(dqOut),
    .dqOe(dqOe));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // --------------------------------
  // helpers
  // --------------------------------
  task automatic check(input string what, input logic [35:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic rd_check(input logic [21:0] a, input logic [35:0] e0, e1);
    logic [35:0] w0, w1;
    model.rd(a, w0, w1);
    check("word0", w0, e0);
    check("word1", w1, e1);
  endtask : rd_check

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_order();
    model.wr(22'h4, 36'h111111111, 36'h222222222, 4'h0, 4'h0, 1'b0);
    rd_check(22'h4, 36'h111111111, 36'h222222222);
    model.wr(22'h5, 36'h333333333, 36'h444444444, 4'h0, 4'h0, 1'b0);
    rd_check(22'h5, 36'h333333333, 36'h444444444);
    rd_check(22'h4, 36'h444444444, 36'h333333333);
    $display("test order done");
  endtask : t_order

  task automatic t_lanes();
    for (int i = 0; i < 4; i++) begin
      model.wr(22'h8, {36{1'b1}}, {36{1'b1}}, 4'h0, 4'h0, 1'b0);
      model.wr(22'h8, 36'h0, 36'h0, 4'h1 << i, 4'h1 << ((i + 1) % 4), 1'b0);
      m0 = 36'h1ff << (9 * i);
      m1 = 36'h1ff << (9 * ((i + 1) % 4));
      rd_check(22'h8, m0, m1);
    end
    $display("test lanes done");
  endtask : t_lanes

  task automatic t_no_load();
    model.wr(22'hc, 36'h5a5a5a5a5, 36'ha5a5a5a5a, 4'h0, 4'h0, 1'b0);
    model.wr(22'hc, 36'h0, 36'h0, 4'h0, 4'h0, 1'b1);
    rd_check(22'hc, 36'h5a5a5a5a5, 36'ha5a5a5a5a);
    $display("test no load done");
  endtask : t_no_load

  task automatic t_modes();
    @(posedge core_clk);
    #1;
    pllDisableN = 1'b0;
    repeat (10) @(posedge core_clk);
    rd_check(22'h4, 36'h444444444, 36'h333333333);
    @(posedge core_clk);
    #1;
    pllDisableN = 1'b1;
    singleClockMode = 1'b1;
    repeat (10) @(posedge core_clk);
    model.wr(22'h6, 36'h0abcdef01, 36'h123456789, 4'h0, 4'h0, 1'b0);
    rd_check(22'h6, 36'h0abcdef01, 36'h123456789);
    @(posedge core_clk);
    #1;
    singleClockMode = 1'b0;
    repeat (10) @(posedge core_clk);
    $display("test modes done");
  endtask : t_modes

  // --------------------------------
  // main sequence and watchdog
  // --------------------------------
  initial begin
    mismatches = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    singleClockMode = 1'b0;
    pllDisableN = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    check("dqOe", 36'(dqOe), 36'h0);
    check("dqOut", dqOut, 36'h0);
    check("bufReady", 36'(wrBufReady), 36'h1);
    repeat (6) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    repeat (8) @(posedge core_clk);
    $display("test reset done");
    t_order();
    t_lanes();
    t_no_load();
    t_modes();
    wrap_up();
  end

  // whole run needs about 30 us
  initial begin
    #2000000;
    mismatches++;
    $display("ERROR watchdog expected finish seen hang");
    wrap_up();
  end
endmodule : dsp_access_port_tb_top
